// File: mdv_cfg.svh
// timing counts, scaling constants and widths for the meter display value select block
`ifndef MDV_CFG_SVH
`define MDV_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define MDV_CLK_HZ 100000000
`define MDV_CAL_HOLD_MS 2000
`define MDV_CAL_HOLD_CYC (`MDV_CLK_HZ / 1000 * `MDV_CAL_HOLD_MS)
`define MDV_REFRESH_MHZ 2500
`define MDV_REFRESH_CYC (`MDV_CLK_HZ / `MDV_REFRESH_MHZ * 1000)
`define MDV_TMR_W 28

// ----------------------------------------------------------------
// scaling of the converter ratio into display counts
// ----------------------------------------------------------------
`define MDV_RATIO_W 24
`define MDV_RATIO_FRAC 23
`define MDV_FS_45 20000
`define MDV_FS_35 2000
`define MDV_GAIN_NUM 1024
`define MDV_GAIN_DEN 1000
`define MDV_LOW_SPAN_MUL 10
`define MDV_GAIN_W 18
`define MDV_CNT_W 18

// ----------------------------------------------------------------
// synchroniser and pin indices
// ----------------------------------------------------------------
`define MDV_SYNC_N 3
`define MDV_PIN_FREEZE 0
`define MDV_PIN_PEAK 1
`define MDV_PIN_RANGE 2

`endif

// File: mdv_pkg.sv
// types shared by the meter display value select block
package mdv_pkg;
  `include "mdv_cfg.svh"

  // one display reading: range flags plus signed count
  typedef struct packed {
    logic over;
    logic under;
    logic signed [`MDV_CNT_W-1:0] count;
  } mdv_disp_t;

  // peak tracker states
  typedef enum logic {
    MDV_PK_IDLE,
    MDV_PK_TRACK
  } mdv_peak_st_t;
endpackage

// File: mdv_scale.sv
// scaler: converter ratio to signed display count with range flags
`timescale 1ns/1ps
`include "mdv_cfg.svh"
module mdv_scale
  import mdv_pkg::*;
#(
  parameter bit DIGITS45 = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic res_valid_in,
  input wire logic signed [`MDV_RATIO_W-1:0] ratio_in,
  input wire logic low_span_in,
  output logic valid_out,
  output mdv_disp_t res_out
);
  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int FS = DIGITS45 ? `MDV_FS_45 : `MDV_FS_35; // full-scale count
  localparam int GAIN_HI = FS * `MDV_GAIN_NUM / `MDV_GAIN_DEN; // 1.024 x full scale
  localparam int PW = `MDV_RATIO_W + `MDV_GAIN_W + 1; // product width

  logic valid_ff; // one-cycle result strobe
  mdv_disp_t res_ff; // registered reading
  logic nxt_valid;
  mdv_disp_t nxt_res;
  logic [`MDV_GAIN_W-1:0] gain; // span dependent gain
  logic signed [PW-1:0] prod; // ratio times gain
  logic signed [19:0] cnt; // count before clipping

  // ----------------------------------------------------------------
  // scaling and clipping
  // ----------------------------------------------------------------
  // ratio is a signed fraction, so the top bits of the product are the count
  always_comb begin
    gain = low_span_in ? `MDV_GAIN_W'(GAIN_HI * `MDV_LOW_SPAN_MUL)
                       : `MDV_GAIN_W'(GAIN_HI);
    prod = ratio_in * $signed({1'b0, gain});
    // negative inputs get one count added, as the transfer law asks
    cnt = prod[PW-1-:20] + 20'(ratio_in < 0);
    nxt_valid = res_valid_in;
    nxt_res = res_ff;
    if (res_valid_in) begin
      nxt_res.over = (cnt > 20'(FS - 1));
      nxt_res.under = (cnt < -20'(FS - 1));
      if (nxt_res.over) begin
        nxt_res.count = `MDV_CNT_W'(FS); // saturate so peak compare stays ordered
      end else if (nxt_res.under) begin
        nxt_res.count = -`MDV_CNT_W'(FS);
      end else begin
        nxt_res.count = cnt[`MDV_CNT_W-1:0];
      end
    end
  end

  // register stage
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      valid_ff <= 1'b0;
      res_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      res_ff <= nxt_res;
    end
  end

  assign valid_out = valid_ff;
  assign res_out = res_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OVER_SAT: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    res_ff.over |-> (res_ff.count == `MDV_CNT_W'(FS)) && !res_ff.under)
    else $error("overrange reading not saturated");
  AST_NEG_ADD: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    res_valid_in && ratio_in == -`MDV_RATIO_W'sd1 |=> res_ff.count == 0)
    else $error("negative offset count wrong");
endmodule

// File: mdv_top.sv
// meter display value select: peak, freeze, calibration request and refresh
//
// What this block does
// - freeze held over 2 s starts calibration
// - peak mode shows only highest seen value
// - peak start loads current result first
// - new result replaces peak only if larger
// - peak pin low clears peak, stops tracking
// - freeze keeps shown reading unchanged
// - 4.5 digits: 1.024 x ratio x 20000 scaling
// - 3.5 digits: 1.024 x ratio x 2000 scaling
// - priority: freeze, then peak, then latest
// - display refreshes at 2.5 Hz
// - overrange shows 1, underrange shows -1; here count saturates at FS / -FS with over / under set
`timescale 1ns/1ps
`include "mdv_cfg.svh"
module mdv_top
  import mdv_pkg::*;
#(
  parameter bit DIGITS45 = 1'b1, // 4.5-digit resolution
  parameter bit CAL_CAPABLE = 1'b1, // on-demand calibration present
  parameter int unsigned CAL_HOLD_CYC = `MDV_CAL_HOLD_CYC,
  parameter int unsigned REFRESH_CYC = `MDV_REFRESH_CYC
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic freeze_pin_in,
  input wire logic peak_pin_in,
  input wire logic range_pin_in,
  input wire logic res_valid_in,
  input wire logic signed [`MDV_RATIO_W-1:0] ratio_in,
  output mdv_disp_t disp_out,
  output logic cal_start_out,
  output logic peak_active_out,
  output logic hold_active_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw; // freeze, peak, range
  logic [2:0] pin_lvl_ff; // filtered levels
  logic [2:0] nxt_pin_lvl;
  logic [`MDV_SYNC_N-1:0] sync_ff [3]; // three-stage chains

  assign pin_raw = {range_pin_in, peak_pin_in, freeze_pin_in};

  // level follows only when stages two and three agree
  always_comb begin
    nxt_pin_lvl = pin_lvl_ff;
    for (int i = 0; i < 3; i++) begin
      if (sync_ff[i][1] == sync_ff[i][2]) begin
        nxt_pin_lvl[i] = sync_ff[i][2];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      // stage 0 feeds stage 1 only
      always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
          sync_ff[g] <= '0;
        end else begin
          sync_ff[g] <= {sync_ff[g][1:0], pin_raw[g]};
        end
      end
    end
  endgenerate

  // filtered level registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pin_lvl_ff <= '0;
    end else begin
      pin_lvl_ff <= nxt_pin_lvl;
    end
  end

  logic freeze_lvl; // freeze requested
  logic peak_lvl; // peak tracking requested
  logic low_span; // 200 mV span selected
  assign freeze_lvl = pin_lvl_ff[`MDV_PIN_FREEZE];
  assign peak_lvl = pin_lvl_ff[`MDV_PIN_PEAK];
  assign low_span = pin_lvl_ff[`MDV_PIN_RANGE];

  // ----------------------------------------------------------------
  // scaling of new results
  // ----------------------------------------------------------------
  logic new_valid; // one-cycle strobe of scaled result
  mdv_disp_t new_res; // scaled result

  mdv_scale #(
    .DIGITS45(DIGITS45)
  ) u_scale (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .res_valid_in(res_valid_in),
    .ratio_in(ratio_in),
    .low_span_in(low_span),
    .valid_out(new_valid),
    .res_out(new_res)
  );

  // ----------------------------------------------------------------
  // latest result and peak tracker
  // ----------------------------------------------------------------
  mdv_disp_t latest_ff, nxt_latest; // most recent scaled result
  mdv_disp_t peak_val_ff, nxt_peak_val; // stored peak
  mdv_peak_st_t peak_st_ff, nxt_peak_st;

  always_comb begin
    nxt_latest = new_valid ? new_res : latest_ff;
    nxt_peak_val = peak_val_ff;
    nxt_peak_st = peak_st_ff;
    case (peak_st_ff)
      MDV_PK_IDLE: begin
        if (peak_lvl) begin
          // start from the freshest value, even one arriving now
          nxt_peak_val = nxt_latest;
          nxt_peak_st = MDV_PK_TRACK;
        end
      end
      MDV_PK_TRACK: begin
        if (!peak_lvl) begin
          nxt_peak_val = '0;
          nxt_peak_st = MDV_PK_IDLE;
        end else if (new_valid && new_res.count > peak_val_ff.count) begin
          nxt_peak_val = new_res;
        end
      end
      default: nxt_peak_st = MDV_PK_IDLE;
    endcase
  end

  // peak tracker registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      latest_ff <= '0;
      peak_val_ff <= '0;
      peak_st_ff <= MDV_PK_IDLE;
    end else begin
      latest_ff <= nxt_latest;
      peak_val_ff <= nxt_peak_val;
      peak_st_ff <= nxt_peak_st;
    end
  end

  // ----------------------------------------------------------------
  // refresh divider and display register
  // ----------------------------------------------------------------
  logic [`MDV_TMR_W-1:0] ref_cnt_ff, nxt_ref_cnt; // refresh divider
  logic tick_ff, nxt_tick; // one-cycle refresh enable
  mdv_disp_t disp_ff, nxt_disp; // shown reading
  logic hold_ff, nxt_hold; // freeze active flag

  always_comb begin
    nxt_tick = 1'b0;
    nxt_ref_cnt = ref_cnt_ff + 1'b1;
    if (ref_cnt_ff == `MDV_TMR_W'(REFRESH_CYC - 1)) begin
      nxt_ref_cnt = '0;
      nxt_tick = 1'b1;
    end
    nxt_hold = freeze_lvl;
    nxt_disp = disp_ff;
    // frozen display simply keeps its own value, so no copy can go stale
    if (tick_ff && !freeze_lvl) begin
      nxt_disp = (peak_st_ff == MDV_PK_TRACK) ? peak_val_ff : latest_ff;
    end
  end

  // display registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ref_cnt_ff <= '0;
      tick_ff <= 1'b0;
      disp_ff <= '0;
      hold_ff <= 1'b0;
    end else begin
      ref_cnt_ff <= nxt_ref_cnt;
      tick_ff <= nxt_tick;
      disp_ff <= nxt_disp;
      hold_ff <= nxt_hold;
    end
  end

  // ----------------------------------------------------------------
  // enhanced calibration request
  // ----------------------------------------------------------------
  logic [`MDV_TMR_W-1:0] cal_cnt_ff, nxt_cal_cnt; // freeze hold timer
  logic cal_ff, nxt_cal; // calibration start pulse
  logic pwrup_ff, nxt_pwrup; // power-up request already made

  // counter sticks at the limit so one long press asks only once
  always_comb begin
    nxt_pwrup = 1'b1;
    nxt_cal = !pwrup_ff; // power-up calibration
    nxt_cal_cnt = cal_cnt_ff;
    if (!freeze_lvl || !CAL_CAPABLE) begin
      nxt_cal_cnt = '0;
    end else if (cal_cnt_ff != `MDV_TMR_W'(CAL_HOLD_CYC)) begin
      nxt_cal_cnt = cal_cnt_ff + 1'b1;
      if (cal_cnt_ff == `MDV_TMR_W'(CAL_HOLD_CYC - 1)) begin
        nxt_cal = 1'b1;
      end
    end
  end

  // calibration registers
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      cal_cnt_ff <= '0;
      cal_ff <= 1'b0;
      pwrup_ff <= 1'b0;
    end else begin
      cal_cnt_ff <= nxt_cal_cnt;
      cal_ff <= nxt_cal;
      pwrup_ff <= nxt_pwrup;
    end
  end

  assign disp_out = disp_ff;
  assign cal_start_out = cal_ff;
  assign peak_active_out = (peak_st_ff == MDV_PK_TRACK);
  assign hold_active_out = hold_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  sequence s_peak_start;
    peak_st_ff == MDV_PK_IDLE && peak_lvl;
  endsequence

  sequence s_freeze_released;
    freeze_lvl ##1 !freeze_lvl;
  endsequence

  AST_CAL_ON_HOLD: assert property (
    cal_ff && pwrup_ff && $past(pwrup_ff) |->
      $past(freeze_lvl) && $past(cal_cnt_ff) == `MDV_TMR_W'(CAL_HOLD_CYC - 1))
    else $error("calibration started without full freeze hold");
  AST_CAL_RESET: assert property (
    s_freeze_released |=> cal_cnt_ff == 0 && !cal_ff)
    else $error("calibration timer not cleared on release");
  AST_PEAK_LOAD: assert property (
    s_peak_start ##0 !new_valid |=> peak_val_ff == $past(latest_ff))
    else $error("peak not loaded from current result");
  AST_PEAK_MONO: assert property (
    peak_st_ff == MDV_PK_TRACK && peak_lvl |=> peak_val_ff.count >= $past(peak_val_ff.count))
    else $error("peak value decreased while tracking");
  AST_PEAK_CLEAR: assert property (
    peak_st_ff == MDV_PK_TRACK && !peak_lvl |=>
      peak_st_ff == MDV_PK_IDLE && peak_val_ff == '0)
    else $error("peak not cleared on disable");
  AST_HOLD_KEEP: assert property (
    freeze_lvl |=> $stable(disp_ff))
    else $error("display changed while frozen");
  AST_PRIO_PEAK: assert property (
    tick_ff && !freeze_lvl && peak_st_ff == MDV_PK_TRACK |=> disp_ff == $past(peak_val_ff))
    else $error("peak value not shown in peak mode");
  AST_REFRESH: assert property (
    !tick_ff |=> $stable(disp_ff))
    else $error("display changed between refresh ticks");
endmodule

// File: mdv_conv_model.sv
// converter result model feeding ratios into the value select block
`timescale 1ns/1ps
`include "mdv_cfg.svh"
module mdv_conv_model
  import mdv_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic req_in,
  input wire logic signed [`MDV_RATIO_W-1:0] val_in,
  output logic res_valid_out,
  output logic signed [`MDV_RATIO_W-1:0] ratio_out
);
  // ----------------------------------------------------------------
  // result strobe and ratio bus
  // ----------------------------------------------------------------
  // idle bus is inverted each cycle so a stale ratio never passes as data
  initial begin
    res_valid_out = 1'b0;
    ratio_out = '0;
  end
  always @(posedge clk_sys_in) begin
    res_valid_out <= req_in;
    ratio_out <= req_in ? val_in : ~ratio_out;
  end
endmodule

// File: meter_display_value_select_tb.sv
// self-checking bench for the meter display value select block
`timescale 1ns/1ps
`include "mdv_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module meter_display_value_select_tb;
  import mdv_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0; // held low for the first 16 cycles
  logic freeze = 1'b0;
  logic peak = 1'b0;
  logic range_sel = 1'b0; // high selects the low span
  logic req = 1'b0;
  logic signed [`MDV_RATIO_W-1:0] val = '0;
  logic res_valid;
  logic signed [`MDV_RATIO_W-1:0] ratio;
  mdv_disp_t disp, disp35, disp_q;
  logic cal, pk_act, hold_act;
  logic cal35, pk35, hold35; // 3.5-digit instance status
  int err_total = 0;
  int checked = 0;
  int cal_n = 0; // calibration pulses since last clear
  int cal35_n = 0; // 3.5-digit calibration pulses over the whole run
  int cyc = 0;
  int last = 0;
  int corner[8] = '{0, -1, 1999, 2000, -2000, -2001, 2047, -2048};
  always #5 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------------------------------
  // partner and the two resolutions
  // ----------------------------------------------------------------
  mdv_conv_model u_conv (.clk_sys_in(clk_sys_in), .req_in(req), .val_in(val),
    .res_valid_out(res_valid), .ratio_out(ratio));
  mdv_top #(.CAL_HOLD_CYC(20), .REFRESH_CYC(8)) u_dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .freeze_pin_in(freeze), .peak_pin_in(peak),
    .range_pin_in(range_sel), .res_valid_in(res_valid), .ratio_in(ratio), .disp_out(disp),
    .cal_start_out(cal), .peak_active_out(pk_act), .hold_active_out(hold_act));
  mdv_top #(.DIGITS45(1'b0), .CAL_CAPABLE(1'b0), .REFRESH_CYC(8)) u_dut35 (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .freeze_pin_in(freeze), .peak_pin_in(peak),
    .range_pin_in(range_sel), .res_valid_in(res_valid), .ratio_in(ratio), .disp_out(disp35),
    .cal_start_out(cal35), .peak_active_out(pk35), .hold_active_out(hold35));
  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  // display may only change a whole number of refresh periods apart
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cal === 1'b1) cal_n++;
    if (cal35 === 1'b1) cal35_n++;
    if (nrst_in === 1'b1 && disp !== disp_q) begin
      if (last > 0) `CHK((cyc - last) % 8, 0)
      last = cyc;
    end
    disp_q = disp;
  end
  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_f(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ratio m*4096 gives exactly 10m counts at 4.5 digits, m at 3.5
  function automatic mdv_disp_t exp_f(int m, bit lo, bit d45);
    int c;
    int fs;
    mdv_disp_t e;
    c = d45 ? 10 * m : m;
    if (lo) c = c * 10;
    if (m < 0) c = c + 1;
    fs = d45 ? 20000 : 2000;
    e.over = (c > fs - 1);
    e.under = (c < 1 - fs);
    if (e.over) c = fs;
    if (e.under) c = -fs;
    e.count = c[`MDV_CNT_W-1:0];
    return e;
  endfunction
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // one raw ratio, then enough time for a refresh to carry it out
  task automatic send_raw(logic signed [`MDV_RATIO_W-1:0] r);
    @(posedge clk_sys_in);
    req <= 1'b1;
    val <= r;
    @(posedge clk_sys_in);
    req <= 1'b0;
    tick(16);
  endtask
  // ratio chosen so the count comes out exact
  task automatic send(int m);
    send_raw(24'(m * 4096));
  endtask
  task automatic wait_peak(logic v);
    int i;
    for (i = 0; i < 20 && pk_act !== v; i++) tick(1);
    checked++;
    if (i == 20) begin
      err_total++;
      $display("unexpected %0t peak state stuck", $time);
      tally_and_finish();
    end
    `CHK(pk35, v)
  endtask
  task automatic check_both(int m, bit lo);
    `CHK(disp, exp_f(m, lo, 1'b1))
    `CHK(disp35, exp_f(m, lo, 1'b0))
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int m;
    int pk;
    bit lo;
    logic [31:0] s;
    s = 32'h00014EA0;
    tick(16);
    nrst_in <= 1'b1;
    tick(8);
    // range edges first, then random spans and values
    foreach (corner[i]) begin
      send(corner[i]);
      check_both(corner[i], 1'b0);
    end
    // smallest negative ratio: floor gives -1, the added count brings it to zero
    send_raw(-24'sd1);
    check_both(0, 1'b0);
    repeat (24) begin
      s = lfsr_f(s);
      m = $signed(s[11:0]);
      lo = s[12];
      range_sel <= lo;
      tick(8);
      send(m);
      check_both(m, lo);
    end
    range_sel <= 1'b0;
    tick(8);
    // peak start loads the present result
    send(-300);
    peak <= 1'b1;
    wait_peak(1'b1);
    tick(16);
    `CHK(disp, exp_f(-300, 1'b0, 1'b1))
    pk = -300;
    repeat (6) begin
      s = lfsr_f(s);
      m = $signed(s[11:0]);
      send(m);
      if (m > pk) pk = m;
      `CHK(disp, exp_f(pk, 1'b0, 1'b1))
    end
    peak <= 1'b0;
    wait_peak(1'b0);
    tick(16);
    `CHK(disp, exp_f(m, 1'b0, 1'b1))
    // a new peak session must not remember the old peak
    send(-500);
    peak <= 1'b1;
    wait_peak(1'b1);
    tick(16);
    `CHK(disp, exp_f(-500, 1'b0, 1'b1))
    // freeze over peak tracking; long press asks for calibration
    cal_n = 0;
    freeze <= 1'b1;
    tick(16);
    send(1000);
    `CHK(disp, exp_f(-500, 1'b0, 1'b1))
    `CHK(hold_act, 1'b1)
    `CHK(hold35, 1'b1)
    freeze <= 1'b0;
    tick(20);
    `CHK(disp, exp_f(1000, 1'b0, 1'b1))
    `CHK(cal_n, 1)
    peak <= 1'b0;
    // short press stays below the qualification time
    cal_n = 0;
    freeze <= 1'b1;
    tick(10);
    freeze <= 1'b0;
    tick(30);
    `CHK(cal_n, 0)
    // without on-demand calibration only the power-up request is made
    `CHK(cal35_n, 1)
    tally_and_finish();
  end
endmodule
